/* verilog/spsdr_pkg.sv */
// package for the serial port sync/data register bank
// assumes a 32-bit register port clocked by ref_clk with a byte address
package spsdr_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_SYNC_BUSY = 8'h1C;  // sync_busy_status
  localparam logic [7:0] OFS_MATCH_ADR = 8'h24;  // match_address
  localparam logic [7:0] OFS_RXTX_BUF  = 8'h28;  // rx_tx_buffer
  localparam logic [7:0] OFS_DBG_HALT  = 8'h30;  // debug_halt_control
  localparam logic [7:0] OFS_CONTROL_A = 8'h00;  // control_a (enable, soft_reset)
  localparam logic [7:0] OFS_CONTROL_B = 8'h04;  // control_b
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SB_SOFT_RESET = 0;              // sync busy: soft_reset
  localparam int SB_ENABLE     = 1;              // sync busy: enable
  localparam int SB_CONTROL_B  = 2;              // sync busy: control_b
  localparam int CA_SOFT_RESET = 0;              // control_a soft_reset bit
  localparam int CA_ENABLE     = 1;              // control_a enable bit
  localparam int CA_RX_ENABLE  = 2;              // control_a receiver enable bit
  localparam int ADR_LO        = 0;              // match address low bit
  localparam int MASK_LO       = 16;             // address mask low bit
  localparam int DBG_STOP_BIT  = 0;              // debug_stop bit
  // ----------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_WORD   = 32'h00000000; // all registers
  localparam int          SYNC_TICKS = 3;            // core-domain crossing latency
endpackage

/* verilog/spsdr_regs.sv */
// register bank: sync busy flags, match address, data buffer, debug halt
// assumes one ref_clk domain; rx words come from the shift engine by valid/ready
`timescale 1ns/1ps
module spsdr_regs #(
  parameter int SYNC_TICKS = spsdr_pkg::SYNC_TICKS  // crossing latency in cycles
) (
  input  wire logic        ref_clk,          // 25 MHz clock
  input  wire logic        rstn,             // async reset, active low
  input  wire logic        reg_sel,          // register access strobe
  input  wire logic        reg_write,        // 1 write, 0 read
  input  wire logic [7:0]  reg_addr,         // byte address
  input  wire logic [31:0] reg_wdata,        // write data
  output logic      [31:0] reg_rdata,        // read data, registered
  output logic             reg_ready,        // access done pulse
  output logic             reg_error,        // bus error with reg_ready
  input  wire logic        rx_valid,         // receive word offered
  input  wire logic [8:0]  rx_word,          // receive word
  output logic             rx_ready,         // buffer can take word
  output logic             tx_valid,         // transmit word available
  output logic      [8:0]  tx_word,          // transmit word
  input  wire logic        tx_ready,         // shift engine takes word
  input  wire logic        debug_halt,       // cpu halted by debugger (pin)
  output logic             unit_enable,      // enable seen by core
  output logic             control_b_pulse,  // control_b value applied to core
  output logic      [31:0] control_b_value,  // control_b value in core
  output logic             soft_reset_pulse, // soft reset to core
  output logic      [7:0]  address_value,    // match address
  output logic      [7:0]  address_mask,     // address mask
  output logic             baud_run,         // baud generator enable
  output logic             receive_complete_flag, // rx buffer not empty
  output logic             tx_buffer_empty_flag   // tx buffer has room
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]  cnt_sr;     // soft reset crossing counter
    logic [1:0]  cnt_en;     // enable crossing counter
    logic [1:0]  cnt_cb;     // control_b crossing counter
    logic        busy_sr;    // soft reset busy
    logic        busy_en;    // enable busy
    logic        busy_cb;    // control_b busy
    logic        en_req;     // requested enable
    logic        en;         // enable seen by core
    logic        rx_en;      // receiver enable
    logic [31:0] cb_req;     // pending control_b
    logic [31:0] cb;         // applied control_b
    logic        cb_pls;     // control_b apply pulse
    logic        sr_pls;     // soft reset pulse
    logic [7:0]  adr;        // match address
    logic [7:0]  msk;        // address mask
    logic        dbg_stop;   // debug stop bit
    logic [8:0]  rx0;        // rx buffer head
    logic [8:0]  rx1;        // rx buffer tail
    logic [1:0]  rx_n;       // rx words held
    logic [8:0]  tx0;        // tx buffer head
    logic [8:0]  tx1;        // tx buffer tail
    logic [1:0]  tx_n;       // tx words held
    logic [31:0] rdata;      // read data
    logic        rdy;        // answer pulse
    logic        err;        // error answer
    logic [1:0]  halt_s;     // debug halt synchroniser
  } spsdr_state_t;

  spsdr_state_t s_q;  // registered state
  spsdr_state_t s_d;  // next state

  // elaboration check on the crossing latency
  if (SYNC_TICKS < 1 || SYNC_TICKS > 3) begin : g_chk
    $error("SYNC_TICKS must be 1 to 3");
  end

  localparam logic [1:0] TICKS = 2'(SYNC_TICKS);  // counter load value

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // counts a crossing down, returns next count
  function automatic logic [1:0] tick(input logic [1:0] c);
    tick = (c != 2'h0) ? c - 2'h1 : 2'h0;
  endfunction

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  logic wr;        // any write
  logic rd;        // any read
  logic discard;   // write refused
  logic rx_push;   // rx word accepted
  logic rx_pop;    // software reads data
  logic tx_push;   // software writes data
  logic tx_pop;    // engine takes tx word
  always_comb
  begin
    s_d     = s_q;
    wr      = reg_sel && reg_write;
    rd      = reg_sel && !reg_write;
    s_d.rdy = reg_sel;
    s_d.err = 1'b0;
    s_d.cb_pls = 1'b0;
    s_d.sr_pls = 1'b0;
    s_d.halt_s = {s_q.halt_s[0], debug_halt};
    // write refusal
    // reset busy refuses all
    // enable busy spares control_a soft reset
    discard = wr && (s_q.busy_sr
              || (s_q.busy_en && !(reg_addr == spsdr_pkg::OFS_CONTROL_A
                                   && reg_wdata[spsdr_pkg::CA_SOFT_RESET]))
              || (s_q.busy_cb && reg_addr == spsdr_pkg::OFS_CONTROL_B));
    if (discard)
    begin
      s_d.err = 1'b1;
    end
    // crossing counters finish busy flags
    s_d.cnt_sr = tick(s_q.cnt_sr);
    s_d.cnt_en = tick(s_q.cnt_en);
    s_d.cnt_cb = tick(s_q.cnt_cb);
    if (s_q.busy_sr && s_q.cnt_sr == 2'h1)
    begin
      // soft reset lands: return to reset values
      s_d        = '0;
      s_d.halt_s = {s_q.halt_s[0], debug_halt};
      s_d.sr_pls = 1'b1;
      s_d.rdy    = reg_sel;
      s_d.err    = discard;
    end
    else
    begin
      if (s_q.busy_en && s_q.cnt_en == 2'h1)
      begin
        s_d.busy_en = 1'b0;
        s_d.en      = s_q.en_req;
      end
      if (s_q.busy_cb && s_q.cnt_cb == 2'h1)
      begin
        s_d.busy_cb = 1'b0;
        s_d.cb      = s_q.cb_req;
        s_d.cb_pls  = 1'b1;
      end
    end
    // rx buffer: two entries
    rx_push = rx_valid && s_q.rx_en && s_q.rx_n != 2'h2;
    // read pops, clearing rx complete when empty
    rx_pop  = rd && reg_addr == spsdr_pkg::OFS_RXTX_BUF && s_q.rx_n != 2'h0;
    tx_pop  = s_q.tx_n != 2'h0 && tx_ready;
    tx_push = 1'b0;
    if (wr && !discard && !s_d.sr_pls)
    begin
      case (reg_addr)
        spsdr_pkg::OFS_CONTROL_A:
        begin
          if (reg_wdata[spsdr_pkg::CA_SOFT_RESET])
          begin
            s_d.busy_sr = 1'b1;
            s_d.cnt_sr  = TICKS;
          end
          else
          begin
            s_d.en_req  = reg_wdata[spsdr_pkg::CA_ENABLE];
            s_d.busy_en = 1'b1;
            s_d.cnt_en  = TICKS;
            s_d.rx_en   = reg_wdata[spsdr_pkg::CA_RX_ENABLE];
          end
        end
        spsdr_pkg::OFS_CONTROL_B:
        begin
          s_d.cb_req = reg_wdata;
          if (s_q.en)
          begin
            s_d.busy_cb = 1'b1;
            s_d.cnt_cb  = TICKS;
          end
          else
          begin
            s_d.cb     = reg_wdata;
            s_d.cb_pls = 1'b1;
          end
        end
        spsdr_pkg::OFS_MATCH_ADR:
        begin
          if (!s_q.en && !s_q.en_req)
          begin
            s_d.msk = reg_wdata[spsdr_pkg::MASK_LO +: 8];
            s_d.adr = reg_wdata[spsdr_pkg::ADR_LO +: 8];
          end
        end
        spsdr_pkg::OFS_RXTX_BUF:
        begin
          tx_push = s_q.tx_n != 2'h2 || tx_pop;
        end
        spsdr_pkg::OFS_DBG_HALT:
        begin
          s_d.dbg_stop = reg_wdata[spsdr_pkg::DBG_STOP_BIT];
        end
        default:
        begin
          s_d.err = 1'b0;
        end
      endcase
    end
    if (!s_d.rx_en || s_d.sr_pls)
    begin
      rx_push = 1'b0;
      s_d.rx_n = 2'h0;
    end
    else
    begin
      case ({rx_push, rx_pop})
        2'b10:
        begin
          if (s_q.rx_n == 2'h0) s_d.rx0 = rx_word;
          else s_d.rx1 = rx_word;
          s_d.rx_n = s_q.rx_n + 2'h1;
        end
        2'b01:
        begin
          s_d.rx0  = s_q.rx1;
          s_d.rx_n = s_q.rx_n - 2'h1;
        end
        2'b11:
        begin
          s_d.rx0 = (s_q.rx_n == 2'h1) ? rx_word : s_q.rx1;
          s_d.rx1 = rx_word;
        end
        default:
        begin
          s_d.rx_n = s_q.rx_n;
        end
      endcase
    end
    if (!s_d.sr_pls)
    begin
      case ({tx_push, tx_pop})
        2'b10:
        begin
          if (s_q.tx_n == 2'h0) s_d.tx0 = reg_wdata[8:0];
          else s_d.tx1 = reg_wdata[8:0];
          s_d.tx_n = s_q.tx_n + 2'h1;
        end
        2'b01:
        begin
          s_d.tx0  = s_q.tx1;
          s_d.tx_n = s_q.tx_n - 2'h1;
        end
        2'b11:
        begin
          s_d.tx0 = (s_q.tx_n == 2'h1) ? reg_wdata[8:0] : s_q.tx1;
          s_d.tx1 = reg_wdata[8:0];
        end
        default:
        begin
          s_d.tx_n = s_q.tx_n;
        end
      endcase
    end
    // read data; reserved bits zero
    s_d.rdata = 32'h00000000;
    if (rd)
    begin
      case (reg_addr)
        spsdr_pkg::OFS_SYNC_BUSY: s_d.rdata = {29'h0, s_q.busy_cb, s_q.busy_en, s_q.busy_sr};
        spsdr_pkg::OFS_MATCH_ADR: s_d.rdata = {8'h00, s_q.msk, 8'h00, s_q.adr};
        spsdr_pkg::OFS_RXTX_BUF:  s_d.rdata = {23'h0, s_q.rx0};
        spsdr_pkg::OFS_DBG_HALT:  s_d.rdata = {31'h0, s_q.dbg_stop};
        spsdr_pkg::OFS_CONTROL_A: s_d.rdata = {29'h0, s_q.rx_en, s_q.en_req, 1'b0};
        spsdr_pkg::OFS_CONTROL_B: s_d.rdata = s_q.cb_req;
        default:                  s_d.rdata = 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reg_rdata        = s_q.rdata;
  assign reg_ready        = s_q.rdy;
  assign reg_error        = s_q.err;
  assign rx_ready         = s_q.rx_en && s_q.rx_n != 2'h2;
  assign tx_valid         = s_q.tx_n != 2'h0;
  assign tx_word          = s_q.tx0;
  assign unit_enable      = s_q.en;
  assign control_b_pulse  = s_q.cb_pls;
  assign control_b_value  = s_q.cb;
  assign soft_reset_pulse = s_q.sr_pls;
  assign address_value    = s_q.adr;
  assign address_mask     = s_q.msk;
  assign baud_run         = !(s_q.dbg_stop && s_q.halt_s[1]);
  assign receive_complete_flag = s_q.rx_n != 2'h0;
  assign tx_buffer_empty_flag  = s_q.tx_n != 2'h2;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_cb_wr_en;
    reg_sel && reg_write && reg_addr == spsdr_pkg::OFS_CONTROL_B && s_q.en
      && !s_q.busy_cb && !s_q.busy_en && !s_q.busy_sr;
  endsequence
  a_cb_busy_set: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_cb_wr_en |=> !reg_error && s_q.busy_cb ##[1:3] !s_q.busy_cb)
    else $error("control_b busy not set then cleared");
  a_cb_rewrite_err: assert property (@(posedge ref_clk) disable iff (!rstn)
    reg_sel && reg_write && reg_addr == spsdr_pkg::OFS_CONTROL_B && s_q.busy_cb |=> reg_error)
    else $error("control_b rewrite not refused");
  a_en_busy_err: assert property (@(posedge ref_clk) disable iff (!rstn)
    reg_sel && reg_write && s_q.busy_en && reg_addr != spsdr_pkg::OFS_CONTROL_A
      |=> reg_error && $stable(address_value) && $stable(s_q.dbg_stop))
    else $error("write during enable sync accepted");
  a_sr_busy_err: assert property (@(posedge ref_clk) disable iff (!rstn)
    reg_sel && reg_write && s_q.busy_sr |=> reg_error && reg_ready)
    else $error("write during reset sync accepted");
  a_sr_busy_end: assert property (@(posedge ref_clk) disable iff (!rstn)
    $rose(s_q.busy_sr) |-> ##[1:3] soft_reset_pulse)
    else $error("soft reset sync never ends");
  a_adr_locked: assert property (@(posedge ref_clk) disable iff (!rstn)
    unit_enable && s_q.en_req |=> ($stable(address_value) && $stable(address_mask)) || soft_reset_pulse)
    else $error("address changed while enabled");
  a_rsvd_zero: assert property (@(posedge ref_clk) disable iff (!rstn)
    reg_sel && !reg_write && reg_addr == spsdr_pkg::OFS_RXTX_BUF |=> reg_rdata[31:9] == 23'h0)
    else $error("reserved data bits not zero");
  a_rxc_clear: assert property (@(posedge ref_clk) disable iff (!rstn)
    reg_sel && !reg_write && reg_addr == spsdr_pkg::OFS_RXTX_BUF && s_q.rx_n == 2'h1 && !rx_valid
      |=> !receive_complete_flag)
    else $error("rx complete not cleared by read");
  a_dbg_halt: assert property (@(posedge ref_clk) disable iff (!rstn)
    debug_halt ##1 debug_halt ##1 s_q.dbg_stop |-> !baud_run)
    else $error("baud generator not halted");
endmodule

/* testbench/tb_serial_port_sync_data_regs.sv */
// self-checking bench for the sync/data register bank
// assumes spsdr_pkg is compiled first; drives all inputs on the falling edge
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module tb_serial_port_sync_data_regs;
  // ------------------------------------------------------------------
  // signals
  // ------------------------------------------------------------------
  logic        ref_clk;      // 25 MHz clock
  logic        rstn;         // async reset, active low
  logic        reg_sel;      // access strobe
  logic        reg_write;    // write select
  logic [7:0]  reg_addr;     // byte address
  logic [31:0] reg_wdata;    // write data
  logic [31:0] reg_rdata;    // read data
  logic        reg_ready;    // access done
  logic        reg_error;    // discarded write
  logic        rx_valid;     // receive word offered
  logic [8:0]  rx_word;      // receive word
  logic        rx_ready;     // buffer has room
  logic        tx_valid;     // transmit word out
  logic [8:0]  tx_word;      // transmit word
  logic        tx_ready;     // engine takes word
  logic        debug_halt;   // debugger halt pin
  logic        unit_enable;  // core enable
  logic        cb_pulse;     // control_b applied
  logic [31:0] cb_value;     // control_b in core
  logic        sr_pulse;     // soft reset to core
  logic [7:0]  adr_value;    // match address
  logic [7:0]  adr_mask;     // address mask
  logic        baud_run;     // baud generator run
  logic        rc_flag;      // receive complete
  logic        te_flag;      // tx buffer empty
  int          mismatches;   // failed compares
  int          n_compared;   // compares made
  int          cycles;       // timeout counter
  int          n_srst;       // soft reset pulses seen
  int          n_cbp;        // control_b apply pulses seen

  spsdr_regs uut (.ref_clk(ref_clk), .rstn(rstn), .reg_sel(reg_sel), .reg_write(reg_write),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ready(reg_ready),
    .reg_error(reg_error), .rx_valid(rx_valid), .rx_word(rx_word), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_word(tx_word), .tx_ready(tx_ready), .debug_halt(debug_halt),
    .unit_enable(unit_enable), .control_b_pulse(cb_pulse), .control_b_value(cb_value),
    .soft_reset_pulse(sr_pulse), .address_value(adr_value), .address_mask(adr_mask),
    .baud_run(baud_run), .receive_complete_flag(rc_flag), .tx_buffer_empty_flag(te_flag));

  // ------------------------------------------------------------------
  // clock, timeout and pulse counting
  // ------------------------------------------------------------------
  // free running clock, 40 ns period
  always #20 ref_clk = ~ref_clk;
  // cut a hang short after a generous ceiling
  always @(posedge ref_clk)
  begin
    cycles++;
    if (sr_pulse === 1'b1)
      n_srst++;
    if (cb_pulse === 1'b1)
      n_cbp++;
    if (cycles == 3000)
    begin
      mismatches++;
      complete_run();
    end
  end

  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  // one register access; answer sampled in the cycle after the strobe
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] exp_d, input logic exp_e);
    @(negedge ref_clk);
    reg_sel   = 1'b1;
    reg_write = w;
    reg_addr  = a;
    reg_wdata = d;
    @(negedge ref_clk);
    reg_sel = 1'b0;
    `CHK("ready", 1'b1, reg_ready)
    `CHK("error", exp_e, reg_error)
    if (!w)
      `CHK("rdata", exp_d, reg_rdata)
  endtask
  // register write with expected error answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
    acc(1'b1, a, d, 32'h00000000, e);
  endtask
  // register read with expected value
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h00000000, e, 1'b0);
  endtask
  // idle cycles so a sync window runs out
  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // offer one receive word and hold it until taken
  task automatic push(input logic [8:0] w);
    int k;
    @(negedge ref_clk);
    rx_valid = 1'b1;
    rx_word  = w;
    for (k = 0; k < 20 && rx_ready !== 1'b1; k++)
      @(negedge ref_clk);
    @(negedge ref_clk);
    rx_valid = 1'b0;
    rx_word  = ~w;
  endtask
  // wait bounded for the core enable level
  task automatic wait_en(input logic v);
    int k;
    for (k = 0; k < 20 && unit_enable !== v; k++)
      @(negedge ref_clk);
    `CHK("unit_enable", v, unit_enable)
    idle(2);
  endtask
  // verdict and end of run
  task automatic complete_run();
    if (mismatches == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial
  begin
    ref_clk = 0; rstn = 0; reg_sel = 0; reg_write = 0; reg_addr = 8'h00; reg_wdata = 32'h0;
    rx_valid = 0; rx_word = 9'h000; tx_ready = 0; debug_halt = 0;
    mismatches = 0; n_compared = 0; cycles = 0; n_srst = 0;
    n_cbp = 0;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    rstn = 1'b1;
    rd(spsdr_pkg::OFS_SYNC_BUSY, 32'h00000000);
    rd(spsdr_pkg::OFS_MATCH_ADR, 32'h00000000);
    rd(spsdr_pkg::OFS_RXTX_BUF, 32'h00000000);
    rd(spsdr_pkg::OFS_DBG_HALT, 32'h00000000);
    rd(8'h40, 32'h00000000);
    `CHK("baud_run", 1'b1, baud_run)
    `CHK("te_flag", 1'b1, te_flag)
    wr(spsdr_pkg::OFS_SYNC_BUSY, 32'hFFFFFFFF, 1'b0);
    rd(spsdr_pkg::OFS_SYNC_BUSY, 32'h00000000);
    // mask and address fields, reserved bits zero
    wr(spsdr_pkg::OFS_MATCH_ADR, 32'hFFFFFFFF, 1'b0);
    rd(spsdr_pkg::OFS_MATCH_ADR, 32'h00FF00FF);
    wr(spsdr_pkg::OFS_MATCH_ADR, 32'h00AB00CD, 1'b0);
    `CHK("adr_mask", 8'hAB, adr_mask)
    `CHK("adr_value", 8'hCD, adr_value)
    // debug stop halts baud generator while halted, until the stop bit is cleared
    wr(spsdr_pkg::OFS_DBG_HALT, 32'h000000FF, 1'b0);
    rd(spsdr_pkg::OFS_DBG_HALT, 32'h00000001);
    debug_halt = 1'b1;
    idle(4);
    `CHK("baud_run", 1'b0, baud_run)
    wr(spsdr_pkg::OFS_DBG_HALT, 32'h00000000, 1'b0);
    idle(4);
    `CHK("baud_run", 1'b1, baud_run)
    debug_halt = 1'b0;
    wr(spsdr_pkg::OFS_CONTROL_A, 32'h00000006, 1'b0);
    rd(spsdr_pkg::OFS_SYNC_BUSY, 32'h00000002);
    wait_en(1'b1);
    rd(spsdr_pkg::OFS_SYNC_BUSY, 32'h00000000);
    wr(spsdr_pkg::OFS_MATCH_ADR, 32'h00120034, 1'b0);
    rd(spsdr_pkg::OFS_MATCH_ADR, 32'h00AB00CD);
    wr(spsdr_pkg::OFS_CONTROL_B, 32'h00000005, 1'b0);
    rd(spsdr_pkg::OFS_SYNC_BUSY, 32'h00000004);
    idle(5);
    wr(spsdr_pkg::OFS_CONTROL_B, 32'h00000007, 1'b0);
    wr(spsdr_pkg::OFS_CONTROL_B, 32'h00000009, 1'b1);
    idle(5);
    `CHK("cb_value", 32'h00000007, cb_value)
    // receive words read in order, flag clears
    push(9'h1A5);
    push(9'h05A);
    `CHK("rx_ready", 1'b0, rx_ready)
    `CHK("rc_flag", 1'b1, rc_flag)
    rd(spsdr_pkg::OFS_RXTX_BUF, 32'h000001A5);
    `CHK("rc_flag", 1'b1, rc_flag)
    rd(spsdr_pkg::OFS_RXTX_BUF, 32'h0000005A);
    `CHK("rc_flag", 1'b0, rc_flag)
    // transmit buffer fills while engine stalls, then drains
    `CHK("te_flag", 1'b1, te_flag)
    wr(spsdr_pkg::OFS_RXTX_BUF, 32'h000001FF, 1'b0);
    `CHK("te_flag", 1'b1, te_flag)
    wr(spsdr_pkg::OFS_RXTX_BUF, 32'h000000AA, 1'b0);
    `CHK("te_flag", 1'b0, te_flag)
    `CHK("tx_valid", 1'b1, tx_valid)
    `CHK("tx_word", 9'h1FF, tx_word)
    tx_ready = 1'b1;
    @(negedge ref_clk);
    `CHK("tx_word", 9'h0AA, tx_word)
    @(negedge ref_clk);
    tx_ready = 1'b0;
    `CHK("tx_valid", 1'b0, tx_valid)
    `CHK("te_flag", 1'b1, te_flag)
    wr(spsdr_pkg::OFS_CONTROL_A, 32'h00000006, 1'b0);
    wr(spsdr_pkg::OFS_DBG_HALT, 32'h00000001, 1'b1);
    idle(5);
    rd(spsdr_pkg::OFS_DBG_HALT, 32'h00000000);
    // soft reset still taken during enable busy, clears state
    wr(spsdr_pkg::OFS_CONTROL_A, 32'h00000006, 1'b0);
    wr(spsdr_pkg::OFS_CONTROL_A, 32'h00000001, 1'b0);
    idle(6);
    `CHK("unit_enable", 1'b0, unit_enable)
    `CHK("adr_value", 8'h00, adr_value)
    wr(spsdr_pkg::OFS_CONTROL_A, 32'h00000001, 1'b0);
    rd(spsdr_pkg::OFS_SYNC_BUSY, 32'h00000001);
    idle(6);
    // match address write refused during reset busy
    wr(spsdr_pkg::OFS_CONTROL_A, 32'h00000001, 1'b0);
    wr(spsdr_pkg::OFS_MATCH_ADR, 32'h00000011, 1'b1);
    idle(6);
    rd(spsdr_pkg::OFS_MATCH_ADR, 32'h00000000);
    `CHK("n_srst", 3, n_srst)
    `CHK("n_cbp", 2, n_cbp)
    complete_run();
  end
endmodule
